// [bench/ssv_cpu_model.sv]
// Processor model driving the activity input
`timescale 1ns/1ps
module ssv_cpu_model (
   input wire logic CLOCK,
   input wire logic [1:0] mode,
   output logic [1:0] kick
);
   import ssv_pkg::*;
   logic [3:0] cnt = 4'h0;
   initial kick = KICK_LOW;
   always @(negedge CLOCK) begin
      cnt <= cnt + 4'h1;
      if (mode == 2'h2)
         kick <= KICK_FLOAT;
      else if (kick == KICK_FLOAT)
         kick <= KICK_LOW;
      else if (mode == 2'h0 && cnt == 4'hf)
         kick <= (kick == KICK_HIGH) ? KICK_LOW : KICK_HIGH;
   end
endmodule // ssv_cpu_model

// [bench/ssv_supervisor_sva.sv]
// Checker for the supply reset supervisor ports
`timescale 1ns/1ps
module ssv_supervisor_sva #(
   parameter int unsigned RESET_CYCLES_P = 20
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic BELOW_RESET_THRESHOLD,
   input wire logic BELOW_WARNING_LEVEL,
   input wire logic BELOW_BACKUP_SUPPLY,
   input wire logic CHIP_SELECT_IN_N,
   input wire logic RESET_OUT_N,
   input wire logic RESET_OUT,
   input wire logic SUPPLY_WARNING_N,
   input wire logic BACKUP_SUPPLY_SELECT,
   input wire logic CHIP_SELECT_OUT_N
);
   logic [31:0] low_cnt;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         low_cnt <= 32'h0;
      end else begin
         low_cnt <= RESET_OUT_N ? 32'h0 : low_cnt + {31'h0, low_cnt != 32'hffffffff};
      end
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   a_low_reset: assert property (BELOW_RESET_THRESHOLD |=> !RESET_OUT_N) else $error("reset late");
   a_reset_pair: assert property (RESET_OUT == !RESET_OUT_N) else $error("reset pair");
   a_warn_follow: assert property ($past(RST_N) |-> SUPPLY_WARNING_N == !$past(BELOW_WARNING_LEVEL))
      else $error("warning");
   a_backup_sel: assert property ($past(RST_N) |->
      BACKUP_SUPPLY_SELECT == ($past(BELOW_RESET_THRESHOLD) && $past(BELOW_BACKUP_SUPPLY))) else $error("backup");
   a_hold_min: assert property ($rose(RESET_OUT_N) |-> low_cnt >= RESET_CYCLES_P) else $error("short");
   a_gate_shut: assert property (!RESET_OUT_N [*8] |-> CHIP_SELECT_OUT_N) else $error("gate open");
   a_gate_stays: assert property (!RESET_OUT_N && CHIP_SELECT_OUT_N |=> CHIP_SELECT_OUT_N || RESET_OUT_N)
      else $error("gate reopened");
   a_gate_pass: assert property (RESET_OUT_N |-> CHIP_SELECT_OUT_N == $past(CHIP_SELECT_IN_N))
      else $error("no pass");
endmodule // ssv_supervisor_sva

bind ssv_supervisor ssv_supervisor_sva #(.RESET_CYCLES_P(RESET_CYCLES_P)) u_sva (.CLOCK, .RST_N,
   .BELOW_RESET_THRESHOLD, .BELOW_WARNING_LEVEL, .BELOW_BACKUP_SUPPLY, .CHIP_SELECT_IN_N, .RESET_OUT_N,
   .RESET_OUT, .SUPPLY_WARNING_N, .BACKUP_SUPPLY_SELECT, .CHIP_SELECT_OUT_N);

// [bench/ssv_supervisor_tb_top.sv]
// Testbench for the supply reset supervisor
`timescale 1ns/1ps
module ssv_supervisor_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic b_rst = 1'b0;
   logic b_warn = 1'b0;
   logic b_bat = 1'b0;
   logic cs_n = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [1:0] kick;
   logic rout_n;
   logic rout;
   logic warn_n;
   logic bsel;
   logic cs_out_n;
   int err_total = 0;
   int num_checks = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   ssv_cpu_model u_cpu (.CLOCK(clk), .mode(mode), .kick(kick));
   ssv_supervisor #(.RESET_CYCLES_P(20), .WATCHDOG_CYCLES_P(50), .WRITE_CYCLES_P(5)) u_dut (.CLOCK(clk),
      .RST_N(rst_n), .BELOW_RESET_THRESHOLD(b_rst), .BELOW_WARNING_LEVEL(b_warn), .BELOW_BACKUP_SUPPLY(b_bat),
      .ACTIVITY_KICK_IN(kick), .CHIP_SELECT_IN_N(cs_n), .RESET_OUT_N(rout_n), .RESET_OUT(rout),
      .SUPPLY_WARNING_N(warn_n), .BACKUP_SUPPLY_SELECT(bsel), .CHIP_SELECT_OUT_N(cs_out_n));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic check(input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wait_up(output int n);
      n = 0;
      while (rout_n !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic t_supply;
      int n;
      cyc(30);
      check(rout_n, 1'b1);
      b_warn = 1'b1;
      b_bat = 1'b1;
      b_rst = 1'b1;
      cyc(2);
      check(warn_n, 1'b0);
      check(rout_n, 1'b0);
      check(rout, 1'b1);
      check(bsel, 1'b1);
      b_bat = 1'b0;
      cyc(2);
      check(bsel, 1'b0);
      b_rst = 1'b0;
      b_warn = 1'b0;
      cyc(10);
      check(warn_n, 1'b1);
      b_rst = 1'b1;
      cyc(1);
      b_rst = 1'b0;
      wait_up(n);
      check(n >= 20 && n < 26, 1'b1);
      $display("supply test done");
   endtask
   task automatic t_gate;
      int n;
      cs_n = 1'b0;
      cyc(2);
      check(cs_out_n, 1'b0);
      b_rst = 1'b1;
      cyc(2);
      check(cs_out_n, 1'b0);
      cs_n = 1'b1;
      cyc(1);
      check(cs_out_n, 1'b1);
      cs_n = 1'b0;
      cyc(1);
      check(cs_out_n, 1'b1);
      b_rst = 1'b0;
      cyc(30);
      check(cs_out_n, 1'b0);
      b_rst = 1'b1;
      cyc(6);
      check(cs_out_n, 1'b0);
      cyc(1);
      check(cs_out_n, 1'b1);
      check(rout_n, 1'b0);
      b_rst = 1'b0;
      wait_up(n);
      check(n >= 20 && n < 26, 1'b1);
      check(cs_out_n, 1'b0);
      $display("gate test done");
   endtask
   task automatic t_wdog;
      int n;
      cyc(200);
      check(rout_n, 1'b1);
      mode <= 2'h2;
      cyc(200);
      check(rout_n, 1'b1);
      mode <= 2'h1;
      n = 0;
      while (rout_n === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      check(n >= 48 && n < 60, 1'b1);
      check(cs_out_n, 1'b1);
      mode <= 2'h0;
      wait_up(n);
      check(n >= 19 && n < 26, 1'b1);
      $display("watchdog test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      cyc(16);
      rst_n = 1'b1;
      t_supply();
      t_gate();
      t_wdog();
      wrap_up();
   end
   initial begin
      #(25 * 4000);
      err_total++;
      wrap_up();
   end
endmodule // ssv_supervisor_tb_top

// [core/ssv_pkg.sv]
// Package of timing constants and states for the supply reset supervisor
package ssv_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned RESET_TIMEOUT_MS = 200;
   localparam int unsigned WATCHDOG_TIMEOUT_MS = 1600;
   localparam int unsigned WRITE_WINDOW_US = 18;
   localparam int unsigned RESET_CYCLES = (CLK_HZ / 1000) * RESET_TIMEOUT_MS;
   localparam int unsigned WATCHDOG_CYCLES = (CLK_HZ / 1000) * WATCHDOG_TIMEOUT_MS;
   localparam int unsigned WRITE_CYCLES = (CLK_HZ / 1000000) * WRITE_WINDOW_US;
   localparam int unsigned CNT_W = 32;
   localparam logic [1:0] KICK_LOW = 2'h0;
   localparam logic [1:0] KICK_HIGH = 2'h1;
   localparam logic [1:0] KICK_FLOAT = 2'h2;
   typedef enum logic [1:0] {
      SSV_RUN,
      SSV_HOLD
   } ssv_rst_e;
   typedef enum logic [1:0] {
      SSV_PASS,
      SSV_WRITE,
      SSV_BLOCK
   } ssv_gate_e;
endpackage

// [core/ssv_supervisor.sv]
// Top of the supply reset supervisor: reset, watchdog, warning, backup select, chip-select gate
`timescale 1ns/1ps
// Overview of operation
// - Low supply drives reset low on the next clock edge
// - Hold reset 200ms after supply recovers
// - Supply dip restarts reset timeout from zero
// - Every reset lasts at least 200ms
// - Stuck activity input beyond 1.6s resets
// - Floating activity input disables the watchdog
// - Active-high reset is complement of low
// - Warning output low at early-warning level
// - Backup selected when below threshold and backup
// - Gate disabled holds chip-select output high
// - Reset disables gate; otherwise pass through
// - Watchdog cleared by reset or input toggle
// - Write window 18us, closes early on high
module ssv_supervisor #(
   parameter int unsigned RESET_CYCLES_P = ssv_pkg::RESET_CYCLES,
   parameter int unsigned WATCHDOG_CYCLES_P = ssv_pkg::WATCHDOG_CYCLES,
   parameter int unsigned WRITE_CYCLES_P = ssv_pkg::WRITE_CYCLES
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic BELOW_RESET_THRESHOLD,
   input wire logic BELOW_WARNING_LEVEL,
   input wire logic BELOW_BACKUP_SUPPLY,
   input wire logic [1:0] ACTIVITY_KICK_IN,
   input wire logic CHIP_SELECT_IN_N,
   output logic RESET_OUT_N,
   output logic RESET_OUT,
   output logic SUPPLY_WARNING_N,
   output logic BACKUP_SUPPLY_SELECT,
   output logic CHIP_SELECT_OUT_N
);
   import ssv_pkg::*;

   ssv_rst_e rst_state;
   ssv_rst_e next_rst_state;
   ssv_gate_e gate_state;
   ssv_gate_e next_gate_state;
   logic [1:0] kick_sync;
   logic [1:0] kick_prev;
   logic [1:0] next_kick_prev;
   logic kick_toggle;
   logic wd_enabled;
   logic wd_done;
   logic rst_done;
   logic wr_done;
   logic rst_active;
   logic rst_clear;
   logic next_reset_n;
   logic next_warning_n;
   logic next_backup;
   logic next_cs_n;
   logic supply_low;
   logic rst_run;
   logic wd_clear;
   logic wr_clear;
   logic next_reset_out;
   logic [CNT_W-1:0] rst_limit;
   logic [CNT_W-1:0] wd_limit;
   logic [CNT_W-1:0] wr_limit;
   ssv_gate_e gate_entry;

   // Synchronise the tri-level activity code before edge detection
   ssv_sync #(.W($bits(ACTIVITY_KICK_IN))) u_kick_sync (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .d(ACTIVITY_KICK_IN),
      .q(kick_sync)
   );

   // Mid-level code means nobody drives the input
   function automatic logic is_valid_level(input logic [1:0] code);
      is_valid_level = (code == KICK_LOW) || (code == KICK_HIGH);
   endfunction

   function automatic logic is_toggle(input logic [1:0] now_code, input logic [1:0] old_code);
      is_toggle = is_valid_level(now_code) && is_valid_level(old_code) && (now_code != old_code);
   endfunction

   // Write window only for a supply fall during an access
   function automatic ssv_gate_e gate_on_reset(input logic low, input logic cs_n);
      if (low && !cs_n) begin
         gate_on_reset = SSV_WRITE;
      end else begin
         gate_on_reset = SSV_BLOCK;
      end
   endfunction

   function automatic logic gate_value(input ssv_gate_e state, input logic cs_n);
      if (state == SSV_BLOCK) begin
         gate_value = 1'b1;
      end else begin
         gate_value = cs_n;
      end
   endfunction

   assign supply_low = BELOW_RESET_THRESHOLD;
   assign wd_enabled = is_valid_level(kick_sync);
   assign kick_toggle = is_toggle(kick_sync, kick_prev);
   assign rst_active = (rst_state == SSV_HOLD) || supply_low;
   // Timeout restarts while supply is low or on entry to reset
   assign rst_clear = supply_low || (rst_state == SSV_RUN);
   assign rst_run = (rst_state == SSV_HOLD);
   assign wd_clear = rst_active || kick_toggle || !wd_enabled;
   assign wr_clear = (gate_state != SSV_WRITE);
   assign gate_entry = gate_on_reset(supply_low, CHIP_SELECT_IN_N);
   assign rst_limit = CNT_W'(RESET_CYCLES_P);
   assign wd_limit = CNT_W'(WATCHDOG_CYCLES_P);
   assign wr_limit = CNT_W'(WRITE_CYCLES_P);

   ssv_timer #(.W(CNT_W)) u_rst_timer (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .clear(rst_clear),
      .run(rst_run),
      .limit(rst_limit),
      .done(rst_done)
   );

   ssv_timer #(.W(CNT_W)) u_wd_timer (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .clear(wd_clear),
      .run(1'b1),
      .limit(wd_limit),
      .done(wd_done)
   );

   ssv_timer #(.W(CNT_W)) u_wr_timer (
      .CLOCK(CLOCK),
      .RST_N(RST_N),
      .clear(wr_clear),
      .run(1'b1),
      .limit(wr_limit),
      .done(wr_done)
   );

   // Reset sequencing
   always_comb begin
      next_rst_state = rst_state;
      case (rst_state)
         SSV_RUN: begin
            if (BELOW_RESET_THRESHOLD || wd_done) begin
               next_rst_state = SSV_HOLD;
            end
         end
         SSV_HOLD: begin
            if (rst_done && !BELOW_RESET_THRESHOLD) begin
               next_rst_state = SSV_RUN;
            end
         end
         default: next_rst_state = SSV_HOLD;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_state <= SSV_HOLD;
      end else begin
         rst_state <= next_rst_state;
      end
   end

   // Previous activity level for edge detection
   always_comb begin
      next_kick_prev = kick_sync;
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         kick_prev <= KICK_FLOAT;
      end else begin
         kick_prev <= next_kick_prev;
      end
   end

   // Output reset stays low whenever held or supply is low
   always_comb begin
      next_reset_n = !((next_rst_state == SSV_HOLD) || supply_low);
      next_reset_out = !next_reset_n;
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RESET_OUT_N <= 1'b0;
         RESET_OUT <= 1'b1;
      end else begin
         RESET_OUT_N <= next_reset_n;
         RESET_OUT <= next_reset_out;
      end
   end

   // Chip-select gate control
   always_comb begin
      next_gate_state = gate_state;
      case (gate_state)
         SSV_PASS: begin
            if (!next_reset_n) begin
               next_gate_state = gate_entry;
            end
         end
         SSV_WRITE: begin
            if (CHIP_SELECT_IN_N || wr_done) begin
               next_gate_state = SSV_BLOCK;
            end
         end
         SSV_BLOCK: begin
            if (next_reset_n) begin
               next_gate_state = SSV_PASS;
            end
         end
         default: next_gate_state = SSV_BLOCK;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         gate_state <= SSV_BLOCK;
      end else begin
         gate_state <= next_gate_state;
      end
   end

   // Early supply warning
   always_comb begin
      next_warning_n = !BELOW_WARNING_LEVEL;
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         SUPPLY_WARNING_N <= 1'b0;
      end else begin
         SUPPLY_WARNING_N <= next_warning_n;
      end
   end

   // Backup supply select
   always_comb begin
      next_backup = supply_low && BELOW_BACKUP_SUPPLY;
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BACKUP_SUPPLY_SELECT <= 1'b0;
      end else begin
         BACKUP_SUPPLY_SELECT <= next_backup;
      end
   end

   // Gated chip-select output
   always_comb begin
      next_cs_n = gate_value(next_gate_state, CHIP_SELECT_IN_N);
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         CHIP_SELECT_OUT_N <= 1'b1;
      end else begin
         CHIP_SELECT_OUT_N <= next_cs_n;
      end
   end
endmodule // ssv_supervisor

// [core/ssv_sync.sv]
// Two-stage synchroniser for the activity input level
`timescale 1ns/1ps
module ssv_sync #(
   parameter int unsigned W = 2
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;
   always_comb begin
      next_meta = d;
      next_q = meta;
   end
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule // ssv_sync

// [core/ssv_timer.sv]
// Clearable cycle counter with terminal flag
`timescale 1ns/1ps
module ssv_timer #(
   parameter int unsigned W = 32
) (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic clear,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_done;
   always_comb begin
      next_count = count;
      next_done = 1'b0;
      if (clear) begin
         next_count = '0;
      end else if (run) begin
         if (count >= limit - 1'b1) begin
            next_done = 1'b1;
            next_count = '0;
         end else begin
            next_count = count + 1'b1;
         end
      end
   end
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         count <= '0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         done <= next_done;
      end
   end
endmodule // ssv_timer
